// ===== fsr_defines.svh
// command codes, flag positions, reset values and timing counts of the sequencer
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH
`define FSR_CMD_WREN 8'h06
`define FSR_CMD_CLRFLAG 8'h50
`define FSR_CMD_RDSTAT 8'h05
`define FSR_CMD_RDFLAG 8'h70
`define FSR_CMD_PROG 8'h02
`define FSR_CMD_ERASE 8'h20
`define FSR_CMD_SUSP 8'h75
`define FSR_CMD_RESUME 8'h7A
`define FSR_CMD_OTPRD 8'h4B
`define FSR_CMD_OTPPROG 8'h42
`define FSR_FLAG_RESET 8'h80
`define FSR_FLAG_READY 7
`define FSR_FLAG_ESUSP 6
`define FSR_FLAG_EERR 5
`define FSR_FLAG_PFAIL 4
`define FSR_FLAG_PSUSP 2
`define FSR_FLAG_PROT 1
`define FSR_OTP_BYTES 65
`define FSR_OTP_LAST 7'h40
`define FSR_OTP_DISCARD 7'h41
`define FSR_OTP_LOCK_BIT 0
`define FSR_OTP_ERASED 8'hFF
`define FSR_CLK_MHZ 250
`define FSR_T_SUSP_US 30
`define FSR_T_PROG_US 120
`define FSR_T_ERASE_US 400
`define FSR_T_OTP_US 200
`define FSR_CYC(us) ((us) * `FSR_CLK_MHZ)
`endif

// ===== fsr_pkg.sv
// types shared by the sequencer modules
package fsr_pkg;
	typedef enum logic [2:0] {
		PH_CMD = 3'b000,
		PH_ADDR = 3'b001,
		PH_DUMMY = 3'b011,
		PH_DOUT = 3'b010,
		PH_DIN = 3'b110,
		PH_SKIP = 3'b111
	} fsr_phase_e;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_PROG = 2'b01,
		OP_ERASE = 2'b11,
		OP_OTP = 2'b10
	} fsr_op_e;
	typedef logic [23:0] fsr_addr_t;
endpackage

// ===== fsr_otp_if.sv
// link between the command sequencer and the otp store
`timescale 1ns/100ps
interface fsr_otp_if;
	logic stgClr;
	logic stgWr;
	logic [6:0] stgIdx;
	logic [7:0] stgData;
	logic commit;
	logic [6:0] rdIdx;
	logic [7:0] rdData;
	logic locked;
	modport seq (output stgClr, stgWr, stgIdx, stgData, commit, rdIdx, input rdData, locked);
	modport store (input stgClr, stgWr, stgIdx, stgData, commit, rdIdx, output rdData, locked);
endinterface

// ===== fsr_otp_store.sv
// otp array with staging buffer and a lock byte kept until reset erases it
`timescale 1ns/100ps
`include "fsr_defines.svh"
module fsr_otp_store
	import fsr_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	fsr_otp_if.store otp
);
	logic [7:0] memReg [0:`FSR_OTP_BYTES-1];
	logic [7:0] stgReg [0:`FSR_OTP_BYTES-1];
	logic [`FSR_OTP_BYTES-1:0] stgValidReg;
	logic [7:0] rdDataReg;

	// per byte: stage during shift-in, burn on commit; burning only clears bits
	genvar i;
	generate
		for (i = 0; i < `FSR_OTP_BYTES; i++) begin : g_byte
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					memReg[i] <= `FSR_OTP_ERASED;
					stgReg[i] <= `FSR_OTP_ERASED;
					stgValidReg[i] <= 1'b0;
				end else begin
					if (otp.commit && stgValidReg[i]) begin
						memReg[i] <= memReg[i] & stgReg[i]; // a cleared lock bit stays cleared
					end
					if (otp.stgClr || otp.commit) begin
						stgValidReg[i] <= 1'b0;
					end else if (otp.stgWr && otp.stgIdx == 7'(i)) begin
						stgReg[i] <= otp.stgData;
						stgValidReg[i] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// registered read port, index clamped to the control byte
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdDataReg <= `FSR_OTP_ERASED;
		end else begin
			rdDataReg <= memReg[(otp.rdIdx > `FSR_OTP_LAST) ? `FSR_OTP_LAST : otp.rdIdx];
		end
	end

	assign otp.rdData = rdDataReg;
	assign otp.locked = !memReg[`FSR_OTP_LAST][`FSR_OTP_LOCK_BIT];

	property p_lock_kept;
		@(posedge core_clk) disable iff (!resetn) otp.locked |=> otp.locked;
	endproperty
	a_lock_kept: assert property (p_lock_kept) else $error("otp lock bit returned to one");
endmodule

// ===== fsr_flash_seq.sv
// suspend/resume and otp command sequencer of the serial flash core
`timescale 1ns/100ps
`include "fsr_defines.svh"

module fsr_flash_seq
	import fsr_pkg::*;
#(
	parameter logic [31:0] SUSP_CYC = `FSR_CYC(`FSR_T_SUSP_US),
	parameter logic [31:0] PROG_CYC = `FSR_CYC(`FSR_T_PROG_US),
	parameter logic [31:0] ERASE_CYC = `FSR_CYC(`FSR_T_ERASE_US),
	parameter logic [31:0] OTP_CYC = `FSR_CYC(`FSR_T_OTP_US)
)(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic serialChipSelN,
	input wire logic serialClk,
	input wire logic serialDataInLine,
	output logic serialDataOutLine,
	output logic serialDataOutOe,
	input wire fsr_addr_t readAddr,
	output logic readIndeterminate,
	output logic writeInProgress,
	output logic writeEnableLatch,
	output logic [7:0] flagStatus
);
	logic csS1, csS2, csS3;
	logic clkS1, clkS2, clkS3;
	logic dinS1, dinS2;
	logic csRise, sclkRise, sclkFall, byteDone, execOk;
	logic [7:0] inByte, outByte;
	logic [7:0] shiftInReg, shiftOutReg, cmdReg, flagReg;
	logic [2:0] bitCntReg, outCntReg;
	logic [1:0] addrByteReg;
	logic gotDataReg, welReg, wipReg, doutReg, oeReg, readIndReg;
	fsr_phase_e phaseReg;
	fsr_addr_t addrReg, opAddrReg, pSlotAddrReg, eSlotAddrReg;
	logic [6:0] otpAddrReg;
	fsr_op_e opKindReg;
	logic [31:0] opCntReg, suspCntReg, pSlotCntReg, eSlotCntReg;
	logic suspPendReg, pSlotReg, eSlotReg;
	logic exWren, exClr, exProg, exErase, exSusp, exResume, exOtpProg;
	logic opDone, suspDone, suspStart, resAccept;
	logic progIntoSusp, startProg, startErase, startOtp, otpLockedHit, startAny;

	fsr_otp_if otpBus();

	fsr_otp_store u_store (
		.core_clk(core_clk),
		.resetn(resetn),
		.otp(otpBus.store)
	);

	// next phase once the command byte is in
	function automatic fsr_phase_e cmdPhase(input logic [7:0] code);
		case (code)
			`FSR_CMD_RDSTAT, `FSR_CMD_RDFLAG: cmdPhase = PH_DOUT;
			`FSR_CMD_PROG, `FSR_CMD_ERASE, `FSR_CMD_OTPRD, `FSR_CMD_OTPPROG: cmdPhase = PH_ADDR;
			default: cmdPhase = PH_SKIP;
		endcase
	endfunction

	// address compare at a given granularity (page or sector)
	function automatic logic sameRegion(input fsr_addr_t a, input fsr_addr_t b, input logic sector);
		sameRegion = sector ? (a[23:16] == b[23:16]) : (a[23:8] == b[23:8]);
	endfunction

	// pin synchronisers plus one stage for edge finding
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			csS1 <= 1'b1;
			csS2 <= 1'b1;
			csS3 <= 1'b1;
			clkS1 <= 1'b0;
			clkS2 <= 1'b0;
			clkS3 <= 1'b0;
			dinS1 <= 1'b0;
			dinS2 <= 1'b0;
		end else begin
			csS1 <= serialChipSelN;
			csS2 <= csS1;
			csS3 <= csS2;
			clkS1 <= serialClk;
			clkS2 <= clkS1;
			clkS3 <= clkS2;
			dinS1 <= serialDataInLine;
			dinS2 <= dinS1;
		end
	end

	// frame edges and byte completion
	assign csRise = csS2 && !csS3;
	assign sclkRise = clkS2 && !clkS3 && !csS2;
	assign sclkFall = !clkS2 && clkS3 && !csS2;
	assign inByte = {shiftInReg[6:0], dinS2};
	assign byteDone = sclkRise && bitCntReg == 3'd7;
	assign execOk = csRise && bitCntReg == 3'd0;

	// command, address and dummy shifting on rising edges
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			phaseReg <= PH_CMD;
			shiftInReg <= 8'h00;
			bitCntReg <= 3'd0;
			cmdReg <= 8'h00;
			addrReg <= 24'h000000;
			addrByteReg <= 2'd0;
			gotDataReg <= 1'b0;
		end else if (csS2) begin
			phaseReg <= PH_CMD;
			bitCntReg <= 3'd0;
			addrByteReg <= 2'd0;
			gotDataReg <= 1'b0;
		end else if (sclkRise) begin
			shiftInReg <= inByte;
			bitCntReg <= bitCntReg + 3'd1;
			if (bitCntReg == 3'd7) begin
				case (phaseReg)
					PH_CMD: begin
						cmdReg <= inByte;
						phaseReg <= cmdPhase(inByte);
					end
					PH_ADDR: begin
						addrReg <= {addrReg[15:0], inByte};
						addrByteReg <= addrByteReg + 2'd1;
						if (addrByteReg == 2'd2) begin
							phaseReg <= (cmdReg == `FSR_CMD_OTPRD) ? PH_DUMMY : PH_DIN;
						end
					end
					PH_DUMMY: phaseReg <= PH_DOUT;
					PH_DIN: gotDataReg <= 1'b1;
					default: phaseReg <= phaseReg;
				endcase
			end
		end
	end

	// otp byte pointer: starts at the address, steps without wrap
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			otpAddrReg <= 7'h00;
		end else if (byteDone && phaseReg == PH_ADDR && addrByteReg == 2'd2) begin
			if ({addrReg[15:0], inByte} > 24'h000040) begin
				otpAddrReg <= (cmdReg == `FSR_CMD_OTPRD) ? `FSR_OTP_LAST : `FSR_OTP_DISCARD;
			end else begin
				otpAddrReg <= inByte[6:0];
			end
		end else if (otpBus.stgWr) begin
			otpAddrReg <= otpAddrReg + 7'd1; // stops at the discard slot
		end else if (sclkFall && phaseReg == PH_DOUT && outCntReg == 3'd7 && cmdReg == `FSR_CMD_OTPRD
				&& otpAddrReg != `FSR_OTP_LAST) begin
			otpAddrReg <= otpAddrReg + 7'd1; // sticks at the control byte
		end
	end

	// staging writes to the otp store, frozen while a burn runs so status polls keep the staged bytes
	assign otpBus.stgClr = byteDone && phaseReg == PH_CMD && opKindReg != OP_OTP;
	assign otpBus.stgWr = byteDone && phaseReg == PH_DIN && cmdReg == `FSR_CMD_OTPPROG && opKindReg != OP_OTP
		&& otpAddrReg <= `FSR_OTP_LAST;
	assign otpBus.stgIdx = otpAddrReg;
	assign otpBus.stgData = inByte;
	assign otpBus.rdIdx = otpAddrReg;
	assign otpBus.commit = opDone && opKindReg == OP_OTP;

	// byte presented on the output line
	always_comb begin
		case (cmdReg)
			`FSR_CMD_RDSTAT: outByte = {6'h00, welReg, wipReg};
			`FSR_CMD_RDFLAG: outByte = flagReg;
			`FSR_CMD_OTPRD: outByte = otpBus.rdData;
			default: outByte = 8'h00;
		endcase
	end

	// data out on falling edges, released one cycle after the synchronised chip select is high
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			doutReg <= 1'b0;
			oeReg <= 1'b0;
			outCntReg <= 3'd0;
			shiftOutReg <= 8'h00;
		end else if (csS2) begin
			oeReg <= 1'b0;
			outCntReg <= 3'd0;
		end else if (sclkFall && phaseReg == PH_DOUT) begin
			oeReg <= 1'b1;
			outCntReg <= outCntReg + 3'd1;
			if (outCntReg == 3'd0) begin
				doutReg <= outByte[7];
				shiftOutReg <= {outByte[6:0], 1'b0};
			end else begin
				doutReg <= shiftOutReg[7];
				shiftOutReg <= {shiftOutReg[6:0], 1'b0};
			end
		end
	end

	// commands take effect at chip select rise on a byte boundary
	assign exWren = execOk && phaseReg == PH_SKIP && cmdReg == `FSR_CMD_WREN;
	assign exClr = execOk && phaseReg == PH_SKIP && cmdReg == `FSR_CMD_CLRFLAG;
	assign exSusp = execOk && phaseReg == PH_SKIP && cmdReg == `FSR_CMD_SUSP;
	assign exResume = execOk && phaseReg == PH_SKIP && cmdReg == `FSR_CMD_RESUME;
	assign exProg = execOk && cmdReg == `FSR_CMD_PROG && gotDataReg;
	assign exErase = execOk && cmdReg == `FSR_CMD_ERASE && phaseReg == PH_DIN && !gotDataReg;
	assign exOtpProg = execOk && cmdReg == `FSR_CMD_OTPPROG && gotDataReg;

	// operation engine decisions
	assign opDone = opKindReg != OP_NONE && opCntReg == 32'd1;
	assign suspDone = suspPendReg && suspCntReg == 32'd1 && !opDone;
	assign suspStart = exSusp && (opKindReg == OP_PROG || opKindReg == OP_ERASE) && !suspPendReg && !opDone;
	assign resAccept = exResume && opKindReg == OP_NONE && (pSlotReg || eSlotReg);
	assign progIntoSusp = exProg && eSlotReg && sameRegion(addrReg, eSlotAddrReg, 1'b1);
	assign startProg = exProg && welReg && opKindReg == OP_NONE && !pSlotReg && !progIntoSusp;
	assign startErase = exErase && welReg && opKindReg == OP_NONE && !pSlotReg && !eSlotReg;
	assign startOtp = exOtpProg && welReg && opKindReg == OP_NONE && !otpBus.locked;
	assign otpLockedHit = exOtpProg && welReg && otpBus.locked;
	assign startAny = startProg || startErase || startOtp || resAccept;

	// running operation, its timer and the suspend latency timer
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			opKindReg <= OP_NONE;
			opCntReg <= 32'd0;
			opAddrReg <= 24'h000000;
			suspPendReg <= 1'b0;
			suspCntReg <= 32'd0;
		end else if (opDone || suspDone) begin
			opKindReg <= OP_NONE;
			suspPendReg <= 1'b0;
		end else if (opKindReg != OP_NONE) begin
			opCntReg <= opCntReg - 32'd1;
			suspCntReg <= suspCntReg - 32'd1;
			if (suspStart) begin
				suspPendReg <= 1'b1;
				suspCntReg <= SUSP_CYC;
			end
		end else if (resAccept) begin
			// newest suspension resumes first
			opKindReg <= pSlotReg ? OP_PROG : OP_ERASE;
			opCntReg <= pSlotReg ? pSlotCntReg : eSlotCntReg;
			opAddrReg <= pSlotReg ? pSlotAddrReg : eSlotAddrReg; // no lock recheck
		end else if (startProg) begin
			opKindReg <= OP_PROG;
			opCntReg <= PROG_CYC;
			opAddrReg <= addrReg;
		end else if (startErase) begin
			opKindReg <= OP_ERASE;
			opCntReg <= ERASE_CYC;
			opAddrReg <= addrReg;
		end else if (startOtp) begin
			opKindReg <= OP_OTP;
			opCntReg <= OTP_CYC;
		end
	end

	// suspended program slot
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pSlotReg <= 1'b0;
			pSlotCntReg <= 32'd0;
			pSlotAddrReg <= 24'h000000;
		end else if (suspDone && opKindReg == OP_PROG) begin
			pSlotReg <= 1'b1;
			pSlotCntReg <= opCntReg;
			pSlotAddrReg <= opAddrReg;
		end else if (resAccept) begin
			pSlotReg <= 1'b0;
		end
	end

	// suspended erase slot, resumed only once the program slot is empty
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			eSlotReg <= 1'b0;
			eSlotCntReg <= 32'd0;
			eSlotAddrReg <= 24'h000000;
		end else if (suspDone && opKindReg == OP_ERASE) begin
			eSlotReg <= 1'b1;
			eSlotCntReg <= opCntReg;
			eSlotAddrReg <= opAddrReg;
		end else if (resAccept && !pSlotReg) begin
			eSlotReg <= 1'b0;
		end
	end

	// write enable latch; refused commands leave it alone
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			welReg <= 1'b0;
		end else if (exWren) begin
			welReg <= 1'b1;
		end else if (startProg || startErase || startOtp) begin
			welReg <= 1'b0;
		end
	end

	// write-in-progress
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wipReg <= 1'b0;
		end else if (startAny) begin
			wipReg <= 1'b1;
		end else if (opDone || suspDone) begin
			wipReg <= 1'b0;
		end
	end

	// flag status; error sets are written last so they win over a clear
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flagReg <= `FSR_FLAG_RESET;
		end else begin
			if (startAny) begin
				flagReg[`FSR_FLAG_READY] <= 1'b0;
			end else if (opDone || suspDone) begin
				flagReg[`FSR_FLAG_READY] <= 1'b1;
			end
			if (suspStart && opKindReg == OP_PROG) begin
				flagReg[`FSR_FLAG_PSUSP] <= 1'b1;
			end else if ((opDone && opKindReg == OP_PROG) || (resAccept && pSlotReg)) begin
				flagReg[`FSR_FLAG_PSUSP] <= 1'b0;
			end
			if (suspStart && opKindReg == OP_ERASE) begin
				flagReg[`FSR_FLAG_ESUSP] <= 1'b1;
			end else if ((opDone && opKindReg == OP_ERASE) || (resAccept && !pSlotReg)) begin
				flagReg[`FSR_FLAG_ESUSP] <= 1'b0;
			end
			if (exClr) begin
				flagReg[`FSR_FLAG_EERR] <= 1'b0;
				flagReg[`FSR_FLAG_PFAIL] <= 1'b0;
				flagReg[`FSR_FLAG_PROT] <= 1'b0;
			end
			if (progIntoSusp || otpLockedHit) begin
				flagReg[`FSR_FLAG_PFAIL] <= 1'b1;
			end
			if (otpLockedHit) begin
				flagReg[`FSR_FLAG_PROT] <= 1'b1;
			end
		end
	end

	// suspended page or sector reads back indeterminate
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			readIndReg <= 1'b0;
		end else begin
			readIndReg <= (pSlotReg && sameRegion(readAddr, pSlotAddrReg, 1'b0))
				|| (eSlotReg && sameRegion(readAddr, eSlotAddrReg, 1'b1));
		end
	end

	assign serialDataOutLine = doutReg;
	assign serialDataOutOe = oeReg;
	assign readIndeterminate = readIndReg;
	assign writeInProgress = wipReg;
	assign writeEnableLatch = welReg;
	assign flagStatus = flagReg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_psusp_flag;
		suspStart && opKindReg == OP_PROG |=> flagReg[`FSR_FLAG_PSUSP];
	endproperty
	a_psusp_flag: assert property (p_psusp_flag) else $error("program suspend flag not set");
	property p_esusp_flag;
		suspStart && opKindReg == OP_ERASE |=> flagReg[`FSR_FLAG_ESUSP] && !flagReg[`FSR_FLAG_READY];
	endproperty
	a_esusp_flag: assert property (p_esusp_flag) else $error("erase suspend flag wrong");
	property p_ready_susp;
		suspDone |=> flagReg[`FSR_FLAG_READY] && !wipReg && opKindReg == OP_NONE;
	endproperty
	a_ready_susp: assert property (p_ready_susp) else $error("not ready after suspend");
	property p_early_finish;
		opDone && suspPendReg && opKindReg == OP_PROG |=> !flagReg[`FSR_FLAG_PSUSP] && !pSlotReg;
	endproperty
	a_early_finish: assert property (p_early_finish) else $error("finished op left suspended");
	property p_resume_busy;
		resAccept |=> wipReg && !flagReg[`FSR_FLAG_READY] ##1 opKindReg != OP_NONE;
	endproperty
	a_resume_busy: assert property (p_resume_busy) else $error("resume did not restart");
	property p_resume_ignored;
		exResume && !pSlotReg && !eSlotReg && !opDone && !suspDone |=> $stable(opKindReg) && $stable(wipReg);
	endproperty
	a_resume_ignored: assert property (p_resume_ignored) else $error("idle resume acted");
	property p_prog_refused;
		progIntoSusp |=> flagReg[`FSR_FLAG_PFAIL] && welReg == $past(welReg) && opKindReg == $past(opKindReg);
	endproperty
	a_prog_refused: assert property (p_prog_refused) else $error("program into suspended sector");
	property p_otp_no_wel;
		exOtpProg && !welReg && opKindReg == OP_NONE |=> $stable(flagReg) && opKindReg == OP_NONE;
	endproperty
	a_otp_no_wel: assert property (p_otp_no_wel) else $error("otp program ran without latch");
	property p_otp_wip;
		opKindReg == OP_OTP |-> wipReg;
	endproperty
	a_otp_wip: assert property (p_otp_wip) else $error("otp program without wip");
	property p_otp_addr;
		phaseReg == PH_DOUT && cmdReg == `FSR_CMD_OTPRD |-> otpAddrReg <= `FSR_OTP_LAST;
	endproperty
	a_otp_addr: assert property (p_otp_addr) else $error("otp read pointer past control byte");
	property p_cs_release;
		csS2 |=> !serialDataOutOe;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("output driven after deselect");
endmodule

// ===== fsr_host_model.sv
// host controller model driving serial flash frames
`timescale 1ns/100ps
module fsr_host_model (
	input wire logic core_clk,
	output logic serialChipSelN,
	output logic serialClk,
	output logic serialDataInLine,
	input wire logic serialDataOutLine
);
	logic [7:0] txBuf [0:7];
	logic [7:0] rxBuf [0:7];
	// idle bus: select high, clock low
	initial begin
		serialChipSelN = 1'b1;
		serialClk = 1'b0;
		serialDataInLine = 1'b0;
	end
	// one frame, msb first, mode 0, 48 ns clock
	task automatic frame(input int nTx, input int nRx);
		@(negedge core_clk) serialChipSelN = 1'b0;
		repeat (6) @(negedge core_clk);
		for (int i = 0; i < nTx + nRx; i++) begin
			for (int b = 7; b >= 0; b--) begin
				// read phase: input line toggles, not held
				serialDataInLine = (i < nTx) ? txBuf[i][b] : ~serialDataInLine;
				repeat (6) @(negedge core_clk);
				serialClk = 1'b1;
				if (i >= nTx) begin
					rxBuf[i - nTx][b] = serialDataOutLine;
				end
				repeat (6) @(negedge core_clk);
				serialClk = 1'b0;
			end
		end
		repeat (6) @(negedge core_clk);
		serialChipSelN = 1'b1;
		serialDataInLine = ~serialDataInLine;
		repeat (6) @(negedge core_clk);
	endtask
endmodule

// ===== fsr_flash_seq_tb.sv
// self-checking bench of the suspend/resume and otp sequencer
`timescale 1ns/100ps
module fsr_flash_seq_tb;
	import fsr_pkg::*;
	localparam logic [31:0] SUSP = 32'h3C;
	localparam logic [31:0] PROG = 32'h190;
	localparam logic [31:0] ERASE = 32'h3E8;
	localparam logic [31:0] OTPC = 32'h190;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic cs, sclk, din, dout, doe, rdInd, wip, wel;
	logic [7:0] flags;
	fsr_addr_t readAddr = '0;
	logic [7:0] expR [0:3] = '{8'h11, 8'h22, 8'hC3, 8'hC3};
	int miscompares = 0;
	int checks_done = 0;
	// core clock
	always #2 core_clk = ~core_clk;
	// a released output line shows the inverse of its last value
	fsr_host_model fsr_host_model_inst (.core_clk(core_clk), .serialChipSelN(cs), .serialClk(sclk),
		.serialDataInLine(din), .serialDataOutLine(doe ? dout : ~dout));
	fsr_flash_seq #(.SUSP_CYC(SUSP), .PROG_CYC(PROG), .ERASE_CYC(ERASE), .OTP_CYC(OTPC)) fsr_flash_seq_inst (
		.core_clk(core_clk), .resetn(resetn), .serialChipSelN(cs), .serialClk(sclk),
		.serialDataInLine(din), .serialDataOutLine(dout), .serialDataOutOe(doe), .readAddr(readAddr),
		.readIndeterminate(rdInd), .writeInProgress(wip), .writeEnableLatch(wel), .flagStatus(flags));
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic st(input logic [7:0] f, input logic w);
		chk(flags, f);
		chk({7'h00, wip}, {7'h00, w});
	endtask
	task automatic tx(input int nRx, input logic [7:0] b[$]);
		foreach (b[i]) fsr_host_model_inst.txBuf[i] = b[i];
		fsr_host_model_inst.frame(b.size(), nRx);
		@(negedge core_clk);
	endtask
	task automatic rd(input fsr_addr_t a, input logic e);
		readAddr = a;
		repeat (2) @(negedge core_clk);
		chk({7'h00, rdInd}, {7'h00, e});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		st(8'h80, 1'b0);
		// program suspend, read around it, resume
		tx(0, {8'h06});
		tx(0, {8'h02, 8'h01, 8'h23, 8'h00, 8'h5A});
		st(8'h00, 1'b1);
		tx(0, {8'h75});
		repeat (SUSP) @(negedge core_clk);
		tx(1, {8'h70});
		chk(fsr_host_model_inst.rxBuf[0], 8'h84);
		st(8'h84, 1'b0);
		rd(24'h0123FF, 1'b1);
		rd(24'h012400, 1'b0);
		tx(0, {8'h7A});
		st(8'h00, 1'b1);
		repeat (PROG) @(negedge core_clk);
		st(8'h80, 1'b0);
		tx(0, {8'h7A});
		st(8'h80, 1'b0);
		// erase suspend with a nested program suspend
		tx(0, {8'h06});
		tx(0, {8'h20, 8'h05, 8'h10, 8'h00});
		tx(0, {8'h75});
		repeat (SUSP) @(negedge core_clk);
		st(8'hC0, 1'b0);
		rd(24'h05F000, 1'b1);
		tx(0, {8'h06});
		tx(0, {8'h02, 8'h05, 8'h00, 8'h00, 8'hAA});
		st(8'hD0, 1'b0);
		chk({7'h00, wel}, 8'h01);
		tx(0, {8'h50});
		tx(0, {8'h02, 8'h06, 8'h00, 8'h00, 8'h33});
		st(8'h40, 1'b1);
		tx(0, {8'h75});
		repeat (SUSP) @(negedge core_clk);
		st(8'hC4, 1'b0);
		tx(0, {8'h7A});
		st(8'h40, 1'b1);
		repeat (PROG) @(negedge core_clk);
		st(8'hC0, 1'b0);
		tx(0, {8'h7A});
		st(8'h00, 1'b1);
		repeat (ERASE) @(negedge core_clk);
		st(8'h80, 1'b0);
		// suspend arriving inside the last stretch of a program
		tx(0, {8'h06});
		tx(0, {8'h02, 8'h07, 8'h00, 8'h00, 8'h11});
		repeat (PROG - 32'h91) @(negedge core_clk);
		tx(0, {8'h75});
		repeat (SUSP) @(negedge core_clk);
		st(8'h80, 1'b0);
		// otp program, refused then accepted past the end
		tx(0, {8'h42, 8'h00, 8'h00, 8'h3E, 8'h11});
		st(8'h80, 1'b0);
		tx(0, {8'h06});
		tx(0, {8'h42, 8'h00, 8'h00, 8'h3E, 8'h11, 8'h22, 8'hC3, 8'h99});
		chk({7'h00, wip}, 8'h01);
		tx(1, {8'h05});
		chk(fsr_host_model_inst.rxBuf[0], 8'h01);
		repeat (OTPC) @(negedge core_clk);
		chk({7'h00, wip}, 8'h00);
		tx(4, {8'h4B, 8'h00, 8'h00, 8'h3E, 8'h00});
		for (int i = 0; i < 4; i++) chk(fsr_host_model_inst.rxBuf[i], expR[i]);
		chk({7'h00, doe}, 8'h00);
		// lock through the control byte, then try again
		tx(0, {8'h06});
		tx(0, {8'h42, 8'h00, 8'h00, 8'h40, 8'hFE});
		repeat (OTPC) @(negedge core_clk);
		tx(0, {8'h06});
		tx(0, {8'h42, 8'h00, 8'h00, 8'h00, 8'h00});
		st(8'h92, 1'b0);
		chk({7'h00, wel}, 8'h01);
		tx(1, {8'h4B, 8'h00, 8'h00, 8'h00, 8'h00});
		chk(fsr_host_model_inst.rxBuf[0], 8'hFF);
		// power loss while an erase is suspended
		tx(0, {8'h20, 8'h02, 8'h00, 8'h00});
		tx(0, {8'h75});
		repeat (SUSP) @(negedge core_clk);
		st(8'hD2, 1'b0);
		resetn = 1'b0;
		repeat (4) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		st(8'h80, 1'b0);
		tx(0, {8'h7A});
		st(8'h80, 1'b0);
		rd(24'h020000, 1'b0);
		end_of_test();
	end
endmodule
